// ==== core/cmbd_pkg.sv ====
// Purpose: shared constants and types of the move/bit/branch decoder
// Assumes: one opcode byte per fetch strobe from program memory
// Notes: opcodes outside the covered groups decode as illegal
package cmbd_pkg;
    localparam logic [2:0] LEN_ONE = 3'h1;
    localparam logic [2:0] LEN_TWO = 3'h2;
    localparam logic [2:0] LEN_THREE = 3'h3;
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] ACC_SFR_ADDR = 8'he0;
    localparam int NIB_HI_POS = 4;
    localparam int BANK_SEL_POS = 3;

    // operation classes seen by the datapath
    typedef enum logic [4:0] {
        CMBD_OP_ILLEGAL = 5'h00,
        CMBD_OP_LD_ACC_IND = 5'h01,
        CMBD_OP_LD_REG_DIR = 5'h02,
        CMBD_OP_DIR_DIR = 5'h03,
        CMBD_OP_DIR_IMM = 5'h04,
        CMBD_OP_IND_IMM = 5'h05,
        CMBD_OP_DATA_POINTER_16_IMM = 5'h06,
        CMBD_OP_CODE_DATA_POINTER_16 = 5'h07,
        CMBD_OP_CODE_PC = 5'h08,
        CMBD_OP_XRD_IND = 5'h09,
        CMBD_OP_XRD_DATA_POINTER_16 = 5'h0a,
        CMBD_OP_XWR_IND = 5'h0b,
        CMBD_OP_XWR_DATA_POINTER_16 = 5'h0c,
        CMBD_OP_PUSH = 5'h0d,
        CMBD_OP_POP = 5'h0e,
        CMBD_OP_XCH_DIR = 5'h0f,
        CMBD_OP_NIB_SWAP = 5'h10,
        CMBD_OP_ANL_C = 5'h11,
        CMBD_OP_ANL_NC = 5'h12,
        CMBD_OP_ORL_C = 5'h13,
        CMBD_OP_ORL_NC = 5'h14,
        CMBD_OP_BIT_TO_C = 5'h15,
        CMBD_OP_C_TO_BIT = 5'h16,
        CMBD_OP_BR_REL = 5'h17,
        CMBD_OP_JMP_DATA_POINTER_16 = 5'h18,
        CMBD_OP_BR_ACC = 5'h19,
        CMBD_OP_BR_CARRY = 5'h1a,
        CMBD_OP_BR_BIT = 5'h1b,
        CMBD_OP_CMP_BR = 5'h1c,
        CMBD_OP_DEC_BR = 5'h1d,
        CMBD_OP_CALL = 5'h1e
    } cmbd_op_t;

    // decoded result of one opcode
    typedef struct packed {
        cmbd_op_t op;
        logic [2:0] len;
        logic [2:0] cycles;
        logic [2:0] bank_reg;
        logic use_bank;
        logic ptr_sel;
        logic cond_inv;
        logic bit_clear;
        logic [1:0] cmp_src;
    } cmbd_dec_t;

    // one finished instruction handed to the datapath
    typedef struct packed {
        cmbd_dec_t dec;
        logic [7:0] opcode;
        logic [7:0] operand1;
        logic [7:0] operand2;
        logic [15:0] next_pc;
        logic [15:0] rel_target;
    } cmbd_issue_t;
endpackage

// ==== core/cmbd_opdec.sv ====
// Purpose: pure opcode to class/length/cycle table
// Assumes: opcode byte is stable while looked up
// Notes: combinational, no state
`timescale 1ns/1ps
module cmbd_opdec (
    input wire logic [7:0] opcode_i,
    output cmbd_pkg::cmbd_dec_t dec_o
);
    // ************************************************
    // table lookup
    // ************************************************
    always_comb begin
        dec_o = '0;
        dec_o.op = cmbd_pkg::CMBD_OP_ILLEGAL;
        dec_o.len = cmbd_pkg::LEN_ONE;
        dec_o.cycles = cmbd_pkg::CYC_ONE;
        dec_o.bank_reg = opcode_i[2:0];
        dec_o.use_bank = opcode_i[cmbd_pkg::BANK_SEL_POS];
        dec_o.ptr_sel = opcode_i[0];
        if (opcode_i[7:4] == 4'ha && opcode_i[3]) begin
            dec_o.op = cmbd_pkg::CMBD_OP_LD_REG_DIR;
            dec_o.len = cmbd_pkg::LEN_TWO;
            dec_o.cycles = cmbd_pkg::CYC_TWO;
        end else if (opcode_i[7:4] == 4'hb && opcode_i[3]) begin
            dec_o.op = cmbd_pkg::CMBD_OP_CMP_BR;
            dec_o.len = cmbd_pkg::LEN_THREE;
            dec_o.cycles = cmbd_pkg::CYC_TWO;
            dec_o.cmp_src = 2'h2;
        end else if (opcode_i[7:4] == 4'hd && opcode_i[3]) begin
            dec_o.op = cmbd_pkg::CMBD_OP_DEC_BR;
            dec_o.len = cmbd_pkg::LEN_TWO;
            dec_o.cycles = cmbd_pkg::CYC_TWO;
        end else begin
            dec_o.use_bank = 1'b0;
            case (opcode_i)
                8'he6, 8'he7: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_LD_ACC_IND;
                end
                8'h85: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_DIR_DIR;
                    dec_o.len = cmbd_pkg::LEN_THREE;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'h75: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_DIR_IMM;
                    dec_o.len = cmbd_pkg::LEN_THREE;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'h76, 8'h77: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_IND_IMM;
                    dec_o.len = cmbd_pkg::LEN_TWO;
                end
                8'h90: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_DATA_POINTER_16_IMM;
                    dec_o.len = cmbd_pkg::LEN_THREE;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'h93: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_CODE_DATA_POINTER_16;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'h83: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_CODE_PC;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'he2, 8'he3: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_XRD_IND;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'he0: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_XRD_DATA_POINTER_16;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'hf2, 8'hf3: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_XWR_IND;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'hf0: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_XWR_DATA_POINTER_16;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'hc0: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_PUSH;
                    dec_o.len = cmbd_pkg::LEN_TWO;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'hd0: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_POP;
                    dec_o.len = cmbd_pkg::LEN_TWO;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'hc5: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_XCH_DIR;
                    dec_o.len = cmbd_pkg::LEN_TWO;
                end
                8'hd6, 8'hd7: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_NIB_SWAP;
                end
                8'h82, 8'hb0: begin
                    dec_o.op = opcode_i[5] ? cmbd_pkg::CMBD_OP_ANL_NC : cmbd_pkg::CMBD_OP_ANL_C;
                    dec_o.len = cmbd_pkg::LEN_TWO;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'h72, 8'ha0: begin
                    dec_o.op = opcode_i[7] ? cmbd_pkg::CMBD_OP_ORL_NC : cmbd_pkg::CMBD_OP_ORL_C;
                    dec_o.len = cmbd_pkg::LEN_TWO;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'ha2: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_BIT_TO_C;
                    dec_o.len = cmbd_pkg::LEN_TWO;
                end
                8'h92: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_C_TO_BIT;
                    dec_o.len = cmbd_pkg::LEN_TWO;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'h80: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_BR_REL;
                    dec_o.len = cmbd_pkg::LEN_TWO;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'h73: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_JMP_DATA_POINTER_16;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'h60, 8'h70: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_BR_ACC;
                    dec_o.len = cmbd_pkg::LEN_TWO;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                    dec_o.cond_inv = opcode_i[4];
                end
                8'h40, 8'h50: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_BR_CARRY;
                    dec_o.len = cmbd_pkg::LEN_TWO;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                    dec_o.cond_inv = opcode_i[4];
                end
                8'h10, 8'h20, 8'h30: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_BR_BIT;
                    dec_o.len = cmbd_pkg::LEN_THREE;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                    dec_o.cond_inv = (opcode_i == 8'h30);
                    dec_o.bit_clear = (opcode_i == 8'h10);
                end
                8'hb4, 8'hb5, 8'hb6, 8'hb7: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_CMP_BR;
                    dec_o.len = cmbd_pkg::LEN_THREE;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                    dec_o.cmp_src = (opcode_i[1]) ? 2'h3 : {1'b0, opcode_i[0]};
                end
                8'hd5: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_DEC_BR;
                    dec_o.len = cmbd_pkg::LEN_THREE;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                8'h12: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_CALL;
                    dec_o.len = cmbd_pkg::LEN_THREE;
                    dec_o.cycles = cmbd_pkg::CYC_TWO;
                end
                default: begin
                    dec_o.op = cmbd_pkg::CMBD_OP_ILLEGAL;
                end
            endcase
        end
    end
endmodule

// ==== core/cmbd_decoder.sv ====
// Purpose: fetch sequencer around the opcode table
// Assumes: program memory answers each fetch strobe with a byte after any delay, marked by code_valid_i
// Notes: issue output holds one cycle per machine cycle of the instruction
`timescale 1ns/1ps
module cmbd_decoder (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] code_byte_i,
    input wire logic code_valid_i,
    input wire logic [7:0] main_arith_register_i,
    output logic [15:0] fetch_addr_o,
    output logic fetch_req_o,
    output cmbd_pkg::cmbd_issue_t issue_o,
    output logic issue_valid_o,
    output logic exec_busy_o,
    output logic acc_self_move_o,
    output logic illegal_o
);
    // ************************************************
    // state
    // ************************************************
    typedef enum logic [3:0] {
        CMBD_ST_FETCH = 4'h1,
        CMBD_ST_OPER = 4'h2,
        CMBD_ST_EXEC = 4'h4,
        CMBD_ST_WAIT = 4'h8
    } cmbd_state_t;

    typedef struct packed {
        cmbd_state_t st;
        logic [15:0] pc;
        logic [1:0] oper_cnt;
        logic [2:0] cyc_cnt;
        logic fetch_req;
        cmbd_pkg::cmbd_issue_t issue;
        logic issue_valid;
        logic busy;
        logic acc_self;
        logic illegal;
    } cmbd_regs_t;

    cmbd_regs_t state_ff;
    cmbd_regs_t nxt_state;
    cmbd_pkg::cmbd_dec_t dec_w;

    cmbd_opdec u_opdec (
        .opcode_i(code_byte_i),
        .dec_o(dec_w)
    );


    // ************************************************
    // sequencing
    // ************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_state.issue_valid = 1'b0;
        nxt_state.fetch_req = 1'b0;
        case (state_ff.st)
            CMBD_ST_FETCH: begin
                nxt_state.fetch_req = 1'b1;
                nxt_state.busy = 1'b0;
                nxt_state.st = CMBD_ST_WAIT;
            end
            CMBD_ST_WAIT: begin
                // opcode byte arrives; pc steps past it here
                if (code_valid_i) begin
                    nxt_state.pc = state_ff.pc + 16'h0001;
                    nxt_state.issue = '0;
                    nxt_state.issue.dec = dec_w;
                    nxt_state.issue.opcode = code_byte_i;
                    nxt_state.illegal = (dec_w.op == cmbd_pkg::CMBD_OP_ILLEGAL);
                    nxt_state.acc_self = 1'b0;
                    nxt_state.busy = 1'b1;
                    nxt_state.oper_cnt = 2'(dec_w.len - cmbd_pkg::LEN_ONE);
                    nxt_state.cyc_cnt = dec_w.cycles;
                    if (dec_w.len != cmbd_pkg::LEN_ONE) begin
                        nxt_state.fetch_req = 1'b1;
                        nxt_state.st = CMBD_ST_OPER;
                    end else begin
                        nxt_state.st = CMBD_ST_EXEC;
                    end
                end
            end
            CMBD_ST_OPER: begin
                if (code_valid_i) begin
                    nxt_state.pc = state_ff.pc + 16'h0001;
                    nxt_state.oper_cnt = state_ff.oper_cnt - 2'h1;
                    if (state_ff.issue.dec.len - 3'(state_ff.oper_cnt) == cmbd_pkg::LEN_ONE) begin
                        nxt_state.issue.operand1 = code_byte_i;
                    end else begin
                        nxt_state.issue.operand2 = code_byte_i;
                    end
                    if (state_ff.oper_cnt == 2'h1) begin
                        nxt_state.st = CMBD_ST_EXEC;
                    end else begin
                        nxt_state.fetch_req = 1'b1;
                    end
                end
            end
            CMBD_ST_EXEC: begin
                nxt_state.issue.next_pc = state_ff.pc;
                nxt_state.issue.rel_target = state_ff.pc +
                    {{8{state_ff.issue.operand2[7]}}, state_ff.issue.operand2};
                if (state_ff.issue.dec.len == cmbd_pkg::LEN_TWO) begin
                    nxt_state.issue.rel_target = state_ff.pc +
                        {{8{state_ff.issue.operand1[7]}}, state_ff.issue.operand1};
                end
                nxt_state.acc_self = (state_ff.issue.opcode == 8'he5) &&
                    (state_ff.issue.operand1 == cmbd_pkg::ACC_SFR_ADDR);
                nxt_state.issue_valid = 1'b1;
                nxt_state.cyc_cnt = state_ff.cyc_cnt - 3'h1;
                if (state_ff.cyc_cnt == cmbd_pkg::CYC_ONE) begin
                    nxt_state.st = CMBD_ST_FETCH;
                end
            end
            default: begin
                nxt_state.st = CMBD_ST_FETCH;
            end
        endcase
        if (reset_i) begin
            nxt_state = '0;
            nxt_state.st = CMBD_ST_FETCH;
            nxt_state.pc = cmbd_pkg::PC_RESET;
        end
    end

    // register stage
    always_ff @(posedge sys_clk_i) begin
        state_ff <= nxt_state;
    end

    assign fetch_addr_o = state_ff.pc;
    assign fetch_req_o = state_ff.fetch_req;
    assign issue_o = state_ff.issue;
    assign issue_valid_o = state_ff.issue_valid;
    assign exec_busy_o = state_ff.busy;
    assign acc_self_move_o = state_ff.acc_self;
    assign illegal_o = state_ff.illegal;
endmodule

// ==== verification/cmbd_decoder_properties.sv ====
// Purpose: timing and decode relations watched at the decoder ports
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to every decoder instance
`timescale 1ns/1ps
module cmbd_decoder_checker (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] code_byte_i,
    input wire logic code_valid_i,
    input wire logic [7:0] main_arith_register_i,
    input wire logic [15:0] fetch_addr_o,
    input wire logic fetch_req_o,
    input wire cmbd_pkg::cmbd_issue_t issue_o,
    input wire logic issue_valid_o,
    input wire logic exec_busy_o,
    input wire logic acc_self_move_o,
    input wire logic illegal_o
);
    logic [15:0] last_addr_ff;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    // ************************************************************
    // address of the last fetched byte
    // ************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            last_addr_ff <= 16'h0000;
        end else if (fetch_req_o) begin
            last_addr_ff <= fetch_addr_o;
        end
    end

    fetch_pulse_a: assert property (fetch_req_o |=> !fetch_req_o)
        else $error("fetch strobe wider than one cycle");
    issue_no_fetch_a: assert property (issue_valid_o |-> !fetch_req_o)
        else $error("fetch during issue cycles");
    one_cycle_a: assert property ($rose(issue_valid_o) && issue_o.dec.cycles == cmbd_pkg::CYC_ONE |=> !issue_valid_o)
        else $error("one-cycle instruction issued longer");
    two_cycle_a: assert property ($rose(issue_valid_o) && issue_o.dec.cycles == cmbd_pkg::CYC_TWO
        |=> issue_valid_o ##1 !issue_valid_o)
        else $error("two-cycle instruction issue length wrong");
    next_pc_a: assert property ($rose(issue_valid_o) |-> issue_o.next_pc == last_addr_ff + 16'h0001)
        else $error("next pc not past last fetched byte");
    rel_short_a: assert property ($rose(issue_valid_o) && issue_o.dec.len == cmbd_pkg::LEN_TWO
        && issue_o.dec.op inside {cmbd_pkg::CMBD_OP_BR_REL, cmbd_pkg::CMBD_OP_BR_ACC, cmbd_pkg::CMBD_OP_BR_CARRY}
        |-> issue_o.rel_target == issue_o.next_pc + {{8{issue_o.operand1[7]}}, issue_o.operand1})
        else $error("short branch target wrong");
    rel_long_a: assert property ($rose(issue_valid_o) && issue_o.dec.len == cmbd_pkg::LEN_THREE
        && issue_o.dec.op inside {cmbd_pkg::CMBD_OP_BR_BIT, cmbd_pkg::CMBD_OP_CMP_BR, cmbd_pkg::CMBD_OP_DEC_BR}
        |-> issue_o.rel_target == issue_o.next_pc + {{8{issue_o.operand2[7]}}, issue_o.operand2})
        else $error("long branch target wrong");
    bank_sel_a: assert property ($rose(issue_valid_o) && issue_o.opcode[3]
        && issue_o.opcode[7:4] inside {4'ha, 4'hb, 4'hd}
        |-> issue_o.dec.use_bank && issue_o.dec.bank_reg == issue_o.opcode[2:0])
        else $error("bank register select wrong");
    fetch_resume_a: assert property ($fell(issue_valid_o) |-> ##[0:3] fetch_req_o)
        else $error("no fetch after instruction end");
    busy_issue_a: assert property (issue_valid_o |-> exec_busy_o)
        else $error("issue without busy");
endmodule

bind cmbd_decoder cmbd_decoder_checker u_checker (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .code_byte_i(code_byte_i), .code_valid_i(code_valid_i),
    .main_arith_register_i(main_arith_register_i), .fetch_addr_o(fetch_addr_o), .fetch_req_o(fetch_req_o),
    .issue_o(issue_o), .issue_valid_o(issue_valid_o), .exec_busy_o(exec_busy_o),
    .acc_self_move_o(acc_self_move_o), .illegal_o(illegal_o)
);

// ==== verification/cmbd_prog_mem.sv ====
// Purpose: program memory answering decoder fetch strobes
// Assumes: program fits in 256 bytes
// Notes: wait_i adds 0 to 3 cycles; data line toggles when not answering
`timescale 1ns/1ps
module cmbd_prog_mem (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic fetch_req_i,
    input wire logic [15:0] fetch_addr_i,
    input wire logic [1:0] wait_i,
    output logic [7:0] code_byte_o,
    output logic code_valid_o
);
    logic [7:0] mem [0:255];
    logic pend;
    logic [1:0] cnt;
    logic [7:0] addr;

    // one answer per strobe; stale data inverted so it never passes for valid
    always_ff @(posedge sys_clk_i) begin
        code_valid_o <= 1'b0;
        code_byte_o <= ~code_byte_o;
        if (reset_i) begin
            pend <= 1'b0;
            code_byte_o <= 8'h00;
        end else if (pend) begin
            cnt <= cnt - 2'h1;
            if (cnt == 2'h0) begin
                pend <= 1'b0;
                code_valid_o <= 1'b1;
                code_byte_o <= mem[addr];
            end
        end else if (fetch_req_i) begin
            addr <= fetch_addr_i[7:0];
            cnt <= wait_i - 2'h1;
            pend <= (wait_i != 2'h0);
            code_valid_o <= (wait_i == 2'h0);
            code_byte_o <= mem[fetch_addr_i[7:0]];
        end
    end
endmodule

// ==== verification/cpu_move_bit_branch_decoder_bench.sv ====
// Purpose: self-checking run of the decoder over an opcode table
// Assumes: program laid out in line, unconditional branches go to the next byte
// Notes: second run picks table rows at random with repeats, random operands, memory delays and accumulator
`timescale 1ns/1ps
module cpu_move_bit_branch_decoder_bench;
    typedef struct packed {
        logic [7:0] opc;
        logic [4:0] op;
        logic [2:0] len;
        logic [2:0] cyc;
        logic [7:0] o1;
        logic [7:0] o2;
        logic [15:0] npc;
        logic [15:0] rel;
        logic isrel;
        logic bank;
    } cmbd_note_t;
    // opcode, class, length and cycles
    localparam logic [23:0] TBL [0:47] = '{24'he60111, 24'he70111, 24'ha80222, 24'haf0222, 24'h850332,
        24'h750432, 24'h760521, 24'h770521, 24'h900632, 24'h930712, 24'h830812, 24'he20912, 24'he30912,
        24'he00a12, 24'hf20b12, 24'hf30b12, 24'hf00c12, 24'hc00d22, 24'hd00e22, 24'hc50f21, 24'hd61011,
        24'hd71011, 24'h821122, 24'hb01222, 24'h721322, 24'ha01422, 24'ha21521, 24'h921622, 24'h801722,
        24'h731812, 24'h601922, 24'h701922, 24'h401a22, 24'h501a22, 24'h201b32, 24'h301b32, 24'h101b32,
        24'hb51c32, 24'hb41c32, 24'hb81c32, 24'hbf1c32, 24'hb61c32, 24'hb71c32, 24'hd81d22, 24'hdf1d22,
        24'hd51d32, 24'h121e32, 24'h040011};
    logic sys_clk_i;
    logic reset_i;
    logic [7:0] code_byte_i;
    logic code_valid_i;
    logic [7:0] arith_val;
    logic [1:0] wait_r;
    logic [15:0] fetch_addr_o;
    logic fetch_req_o;
    cmbd_pkg::cmbd_issue_t issue_o;
    logic issue_valid_o;
    logic exec_busy_o;
    logic illegal_o;
    logic acc_self_move_o;
    int n_fail = 0;
    int n_compared = 0;
    int n_cycles = 0;
    int run_len = 0;
    int seed;
    bit act = 0;
    cmbd_note_t cur;
    cmbd_note_t notes[$];

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    cmbd_decoder dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .code_byte_i(code_byte_i),
        .code_valid_i(code_valid_i), .main_arith_register_i(arith_val), .fetch_addr_o(fetch_addr_o),
        .fetch_req_o(fetch_req_o), .issue_o(issue_o), .issue_valid_o(issue_valid_o),
        .exec_busy_o(exec_busy_o), .acc_self_move_o(acc_self_move_o), .illegal_o(illegal_o));
    cmbd_prog_mem pm (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .fetch_req_i(fetch_req_o),
        .fetch_addr_i(fetch_addr_o), .wait_i(wait_r), .code_byte_o(code_byte_i), .code_valid_o(code_valid_i));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic build(input bit shuffle);
        int pc;
        int idx;
        cmbd_note_t nt;
        logic [7:0] lastb;
        pc = 0;
        for (int k = 0; k < 48; k++) begin
            idx = shuffle ? $urandom_range(47) : k;
            {nt.opc, nt.op, nt.len, nt.cyc} = {TBL[idx][23:16], TBL[idx][12:8], TBL[idx][6:4], TBL[idx][2:0]};
            nt.o1 = 8'($urandom);
            nt.o2 = 8'($urandom);
            nt.npc = 16'(pc) + 16'(nt.len);
            // fixed targets keep fetch in line
            if (nt.opc == 8'h80) nt.o1 = 8'h00;
            if (nt.opc == 8'h12) {nt.o1, nt.o2} = nt.npc;
            nt.isrel = nt.op inside {5'h17, 5'h19, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
            nt.bank = nt.opc[3] && nt.opc[7:4] inside {4'ha, 4'hb, 4'hd};
            lastb = (nt.len == 3'h3) ? nt.o2 : nt.o1;
            nt.rel = nt.npc + {{8{lastb[7]}}, lastb};
            pm.mem[pc] = nt.opc;
            pm.mem[pc + 1] = nt.o1;
            pm.mem[pc + 2] = nt.o2;
            pc += nt.len;
            notes.push_back(nt);
        end
        for (int a = pc; a < 256; a++) pm.mem[a] = 8'h04;
    endtask

    // fresh accumulator value and memory delay each cycle
    always @(posedge sys_clk_i) begin
        arith_val <= 8'($urandom);
        wait_r <= 2'($urandom);
    end

    // take the oldest note when an issue run starts
    always @(posedge sys_clk_i) begin
        if (act && issue_valid_o !== 1'b1) begin
            act = 0;
            check(16'(run_len), cur.cyc);
        end else if (act) begin
            run_len++;
        end else if (issue_valid_o === 1'b1 && reset_i === 1'b0 && notes.size() > 0) begin
            cur = notes.pop_front();
            act = 1;
            run_len = 1;
            check(issue_o.opcode, cur.opc);
            check(issue_o.dec.op, cur.op);
            check(issue_o.dec.len, cur.len);
            check(illegal_o, cur.op == 5'h00);
            check(issue_o.next_pc, cur.npc);
            if (cur.len > 3'h1) check(issue_o.operand1, cur.o1);
            if (cur.len > 3'h2) check(issue_o.operand2, cur.o2);
            if (cur.isrel) check(issue_o.rel_target, cur.rel);
            if (cur.bank) check({issue_o.dec.use_bank, issue_o.dec.bank_reg}, {1'b1, cur.opc[2:0]});
            if (cur.op == 5'h1b) check(issue_o.dec.bit_clear, cur.opc == 8'h10);
            if (cur.op == 5'h1c) check(issue_o.dec.cmp_src, cur.opc[3] ? 2'h2 : (cur.opc == 8'hb4) ? 2'h0 :
                (cur.opc == 8'hb5) ? 2'h1 : 2'h3);
            if (cur.op inside {5'h19, 5'h1a, 5'h1b}) check(issue_o.dec.cond_inv, cur.opc inside {8'h70, 8'h50, 8'h30});
            if (cur.opc inside {8'he6, 8'he7, 8'h76, 8'h77, 8'he2, 8'he3, 8'hf2, 8'hf3, 8'hd6, 8'hd7, 8'hb6, 8'hb7})
                check(issue_o.dec.ptr_sel, cur.opc[0]);
            check(acc_self_move_o, 1'b0);
        end
    end

    // hang guard, about five times the expected run
    always @(posedge sys_clk_i) begin
        n_cycles++;
        if (n_cycles == 5000) begin
            n_fail++;
            $display("Error %0t: timeout", $time);
            finish_test();
        end
    end

    initial begin
        seed = $urandom(32'h7b080122);
        reset_i = 1'b1;
        for (int r = 0; r < 2; r++) begin
            build(r[0]);
            repeat (4) @(posedge sys_clk_i);
            check({fetch_req_o, issue_valid_o, exec_busy_o}, 3'h0);
            check(fetch_addr_o, 16'h0000);
            reset_i <= 1'b0;
            for (int t = 0; t < 3000 && (notes.size() > 0 || act); t++) @(posedge sys_clk_i);
            check(16'(notes.size()), 16'h0000);
            reset_i <= 1'b1;
            // let reset land before new notes appear, else the monitor may take one
            @(posedge sys_clk_i);
        end
        finish_test();
    end
endmodule
